/* pkg/transfer_pkg.sv */
package transfer_pkg;

    localparam int OP_W = 10;
    localparam int NIB_W = 4;
    localparam int PRESC_W = 8;
    localparam int REG_AW = 4;
    localparam int REG_DW = 8;

    // Opcodes of the four transfer instructions
    localparam logic [OP_W-1:0] OP_TIMER_BIT   = 10'h2AA;
    localparam logic [OP_W-1:0] OP_PRESC_LOAD  = 10'h235;
    localparam logic [OP_W-1:0] OP_PULLUP_FRST = 10'h22D;
    localparam logic [OP_W-1:0] OP_PULLUP_SCND = 10'h22E;

    // Software register map
    localparam logic [REG_AW-1:0] ADDR_CTRL      = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_TIMER_BIT = 4'h1;
    localparam logic [REG_AW-1:0] ADDR_PRESC_CNT = 4'h2;
    localparam logic [REG_AW-1:0] ADDR_PRESC_RLD = 4'h3;
    localparam logic [REG_AW-1:0] ADDR_PULLUP    = 4'h4;
    localparam logic [REG_AW-1:0] ADDR_STATUS    = 4'h5;

    // Field positions
    localparam int CTRL_EXEC_EN_BIT = 0;
    localparam int PRESC_HI_LSB     = 4;
    localparam int PULLUP_SCND_LSB  = 4;
    localparam int STATUS_CNT_LSB   = 4;

    // Reset values
    localparam logic [REG_DW-1:0]  CTRL_RST      = 8'h01;
    localparam logic               TIMER_BIT_RST = 1'h0;
    localparam logic [PRESC_W-1:0] PRESC_RST     = 8'h00;
    localparam logic [NIB_W-1:0]   PULLUP_RST    = 4'h0;
    localparam logic [NIB_W-1:0]   EXEC_CNT_RST  = 4'h0;

    typedef enum logic [2:0] {
        KIND_NONE   = 3'h0,
        KIND_TIMER  = 3'h1,
        KIND_PRESC  = 3'h3,
        KIND_PU_FST = 3'h2,
        KIND_PU_SND = 3'h6
    } op_kind_e;

    function automatic op_kind_e decodeOp(input logic [OP_W-1:0] word);
        op_kind_e kind;
        case (word)
            OP_TIMER_BIT:   kind = KIND_TIMER;
            OP_PRESC_LOAD:  kind = KIND_PRESC;
            OP_PULLUP_FRST: kind = KIND_PU_FST;
            OP_PULLUP_SCND: kind = KIND_PU_SND;
            default:        kind = KIND_NONE;
        endcase
        return kind;
    endfunction

endpackage

/* pkg/exec_if.sv */
`timescale 1ns/1ps
interface exec_if;
    logic                  timerLoad;
    logic                  prescLoad;
    logic                  pullupFirstLoad;
    logic                  pullupSecondLoad;
    transfer_pkg::op_kind_e kind;

    modport dec (
        output timerLoad,
        output prescLoad,
        output pullupFirstLoad,
        output pullupSecondLoad,
        output kind
    );

    modport core (
        input timerLoad,
        input prescLoad,
        input pullupFirstLoad,
        input pullupSecondLoad,
        input kind
    );
endinterface

/* core/transfer_decode.sv */
`timescale 1ns/1ps
module transfer_decode (
    input  wire logic                          instrValid,
    input  wire logic [transfer_pkg::OP_W-1:0] instrWord,
    input  wire logic                          execEnable,
    exec_if.dec                                ex
);
    transfer_pkg::op_kind_e kindNow;

    always_comb begin
        kindNow = transfer_pkg::KIND_NONE;
        if (instrValid && execEnable) begin
            kindNow = transfer_pkg::decodeOp(instrWord);
        end
        ex.kind             = kindNow;
        ex.timerLoad        = (kindNow == transfer_pkg::KIND_TIMER);
        ex.prescLoad        = (kindNow == transfer_pkg::KIND_PRESC);
        ex.pullupFirstLoad  = (kindNow == transfer_pkg::KIND_PU_FST);
        ex.pullupSecondLoad = (kindNow == transfer_pkg::KIND_PU_SND);
    end
endmodule

/* core/transfer_regbus.sv */
`timescale 1ns/1ps
module transfer_regbus (
    input  wire logic                                 core_clk,
    input  wire logic                                 reset,
    input  wire logic [transfer_pkg::REG_AW-1:0]      regAddr,
    input  wire logic [transfer_pkg::REG_DW-1:0]      regWdata,
    input  wire logic                                 regWrite,
    input  wire logic                                 regRead,
    input  wire logic                                 timerBit,
    input  wire logic [transfer_pkg::PRESC_W-1:0]     prescCount,
    input  wire logic [transfer_pkg::PRESC_W-1:0]     prescReload,
    input  wire logic [transfer_pkg::NIB_W-1:0]       pullupFirst,
    input  wire logic [transfer_pkg::NIB_W-1:0]       pullupSecond,
    input  wire logic [2:0]                           lastKind,
    input  wire logic [transfer_pkg::NIB_W-1:0]       execCount,
    output logic      [transfer_pkg::REG_DW-1:0]      regRdata,
    output logic                                      execEnable
);
    logic [transfer_pkg::REG_DW-1:0] ctrl_ff;
    logic [transfer_pkg::REG_DW-1:0] nxt_ctrl;
    logic [transfer_pkg::REG_DW-1:0] rdata_ff;
    logic [transfer_pkg::REG_DW-1:0] nxt_rdata;

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_rdata = 8'h00;
        if (regWrite && regAddr == transfer_pkg::ADDR_CTRL) begin
            nxt_ctrl = 8'h00;
            nxt_ctrl[transfer_pkg::CTRL_EXEC_EN_BIT] = regWdata[transfer_pkg::CTRL_EXEC_EN_BIT];
        end
        // Data appear the cycle after the strobe only; unmapped reads give zero
        if (regRead) begin
            case (regAddr)
                transfer_pkg::ADDR_CTRL:      nxt_rdata = ctrl_ff;
                transfer_pkg::ADDR_TIMER_BIT: nxt_rdata = {7'h00, timerBit};
                transfer_pkg::ADDR_PRESC_CNT: nxt_rdata = prescCount;
                transfer_pkg::ADDR_PRESC_RLD: nxt_rdata = prescReload;
                transfer_pkg::ADDR_PULLUP:    nxt_rdata = {pullupSecond, pullupFirst};
                transfer_pkg::ADDR_STATUS:    nxt_rdata = {execCount, 1'h0, lastKind};
                default:                      nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_ff  <= transfer_pkg::CTRL_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    assign regRdata   = rdata_ff;
    assign execEnable = ctrl_ff[transfer_pkg::CTRL_EXEC_EN_BIT];
endmodule

/* core/accumulator_transfer_exec.sv */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Opcode 2AA is the one-word, one-cycle timer bit transfer.
// - Timer bit transfer copies accumulator bit 0 into timer control bit 0 only.
// - Opcode 235 is the one-word, one-cycle prescaler load.
// - Prescaler load puts register B into bits 7..4 of counter and reload.
// - Prescaler load puts the accumulator into bits 3..0 of counter and reload.
// - First pull-up transfer copies the accumulator into first pull-up register.
// - Opcode 22E copies the accumulator into the second pull-up register.
module accumulator_transfer_exec (
    input  wire logic                              core_clk,
    input  wire logic                              reset,
    input  wire logic                              instrValid,
    input  wire logic [transfer_pkg::OP_W-1:0]     instrWord,
    input  wire logic [transfer_pkg::NIB_W-1:0]    accA,
    input  wire logic [transfer_pkg::NIB_W-1:0]    regB,
    input  wire logic [transfer_pkg::REG_AW-1:0]   regAddr,
    input  wire logic [transfer_pkg::REG_DW-1:0]   regWdata,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    output logic      [transfer_pkg::REG_DW-1:0]   regRdata,
    output logic                                   timerCtrlBit,
    output logic      [transfer_pkg::PRESC_W-1:0]  prescalerCounter,
    output logic      [transfer_pkg::PRESC_W-1:0]  prescalerReload,
    output logic      [transfer_pkg::NIB_W-1:0]    pullupControlFirst,
    output logic      [transfer_pkg::NIB_W-1:0]    pullupControlSecond,
    output logic                                   instrDone,
    output logic                                   carryWrite,
    output logic                                   skipNext
);
    localparam int NW = transfer_pkg::NIB_W;

    exec_if ex ();

    logic                              execEnable;
    logic                              timerBit_ff;
    logic                              nxt_timerBit;
    logic [transfer_pkg::PRESC_W-1:0]  prescCnt_ff;
    logic [transfer_pkg::PRESC_W-1:0]  nxt_prescCnt;
    logic [transfer_pkg::PRESC_W-1:0]  prescRld_ff;
    logic [transfer_pkg::PRESC_W-1:0]  nxt_prescRld;
    logic [NW-1:0]                     puFirst_ff;
    logic [NW-1:0]                     nxt_puFirst;
    logic [NW-1:0]                     puSecond_ff;
    logic [NW-1:0]                     nxt_puSecond;
    logic                              done_ff;
    logic                              nxt_done;
    logic [2:0]                        lastKind_ff;
    logic [2:0]                        nxt_lastKind;
    logic [NW-1:0]                     execCnt_ff;
    logic [NW-1:0]                     nxt_execCnt;
    logic                              carry_ff;
    logic                              skip_ff;

    transfer_decode u_decode (
        .instrValid (instrValid),
        .instrWord  (instrWord),
        .execEnable (execEnable),
        .ex         (ex.dec)
    );

    transfer_regbus u_regbus (
        .core_clk     (core_clk),
        .reset        (reset),
        .regAddr      (regAddr),
        .regWdata     (regWdata),
        .regWrite     (regWrite),
        .regRead      (regRead),
        .timerBit     (timerBit_ff),
        .prescCount   (prescCnt_ff),
        .prescReload  (prescRld_ff),
        .pullupFirst  (puFirst_ff),
        .pullupSecond (puSecond_ff),
        .lastKind     (lastKind_ff),
        .execCount    (execCnt_ff),
        .regRdata     (regRdata),
        .execEnable   (execEnable)
    );

    // Every transfer finishes in the cycle it is presented; no stall path exists
    always_comb begin
        nxt_timerBit = timerBit_ff;
        nxt_prescCnt = prescCnt_ff;
        nxt_prescRld = prescRld_ff;
        nxt_puFirst  = puFirst_ff;
        nxt_puSecond = puSecond_ff;
        nxt_done     = 1'h0;
        nxt_lastKind = lastKind_ff;
        nxt_execCnt  = execCnt_ff;
        if (ex.timerLoad) begin
            nxt_timerBit = accA[0];
        end
        if (ex.prescLoad) begin
            nxt_prescCnt[transfer_pkg::PRESC_HI_LSB +: NW] = regB;
            nxt_prescRld[transfer_pkg::PRESC_HI_LSB +: NW] = regB;
            nxt_prescCnt[0 +: NW] = accA;
            nxt_prescRld[0 +: NW] = accA;
        end
        if (ex.pullupFirstLoad) begin
            nxt_puFirst = accA;
        end
        if (ex.pullupSecondLoad) begin
            nxt_puSecond = accA;
        end
        if (ex.kind != transfer_pkg::KIND_NONE) begin
            nxt_done     = 1'h1;
            nxt_lastKind = ex.kind;
            nxt_execCnt  = NW'(execCnt_ff + 4'h1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            timerBit_ff <= transfer_pkg::TIMER_BIT_RST;
            prescCnt_ff <= transfer_pkg::PRESC_RST;
            prescRld_ff <= transfer_pkg::PRESC_RST;
            puFirst_ff  <= transfer_pkg::PULLUP_RST;
            puSecond_ff <= transfer_pkg::PULLUP_RST;
            done_ff     <= 1'h0;
            lastKind_ff <= 3'(transfer_pkg::KIND_NONE);
            execCnt_ff  <= transfer_pkg::EXEC_CNT_RST;
            carry_ff    <= 1'h0;
            skip_ff     <= 1'h0;
        end else begin
            timerBit_ff <= nxt_timerBit;
            prescCnt_ff <= nxt_prescCnt;
            prescRld_ff <= nxt_prescRld;
            puFirst_ff  <= nxt_puFirst;
            puSecond_ff <= nxt_puSecond;
            done_ff     <= nxt_done;
            lastKind_ff <= nxt_lastKind;
            execCnt_ff  <= nxt_execCnt;
            // Never request a carry write or a skip from these transfers
            carry_ff    <= 1'h0;
            skip_ff     <= 1'h0;
        end
    end

    assign timerCtrlBit        = timerBit_ff;
    assign prescalerCounter    = prescCnt_ff;
    assign prescalerReload     = prescRld_ff;
    assign pullupControlFirst  = puFirst_ff;
    assign pullupControlSecond = puSecond_ff;
    assign instrDone           = done_ff;
    assign carryWrite          = carry_ff;
    assign skipNext            = skip_ff;
endmodule

/* tb/accumulator_transfer_exec_assertions.sv */
`timescale 1ns/1ps
module accumulator_transfer_exec_assertions (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       instrValid,
    input wire logic [9:0] instrWord,
    input wire logic [3:0] accA,
    input wire logic [3:0] regB,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       timerCtrlBit,
    input wire logic [7:0] prescalerCounter,
    input wire logic [7:0] prescalerReload,
    input wire logic [3:0] pullupControlFirst,
    input wire logic [3:0] pullupControlSecond,
    input wire logic       instrDone,
    input wire logic       carryWrite,
    input wire logic       skipNext
);
    // Mirror of the exec enable, which is not visible at the ports
    logic enFf;
    logic nxt_enFf;
    logic isHit;
    always_comb begin
        nxt_enFf = enFf;
        if (regWrite && regAddr == transfer_pkg::ADDR_CTRL) begin
            nxt_enFf = regWdata[0];
        end
        if (reset) begin
            nxt_enFf = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        enFf <= nxt_enFf;
    end
    assign isHit = instrValid && enFf && (instrWord inside {10'h2AA, 10'h235, 10'h22D, 10'h22E});

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence hitSeq(logic [9:0] op);
        instrValid && enFf && instrWord == op;
    endsequence

    timer_copy_a: assert property (hitSeq(10'h2AA) |=>
        {3'h0, timerCtrlBit} == ($past(accA) & 4'h1)) else $error("timer bit copy wrong");
    presc_high_a: assert property (hitSeq(10'h235) |=>
        prescalerCounter[7:4] == $past(regB) && prescalerReload[7:4] == $past(regB))
        else $error("prescaler high nibble wrong");
    presc_low_a: assert property (hitSeq(10'h235) |=>
        prescalerCounter[3:0] == $past(accA) && prescalerReload[3:0] == $past(accA))
        else $error("prescaler low nibble wrong");
    pullup_first_a: assert property (hitSeq(10'h22D) |=>
        pullupControlFirst == $past(accA)) else $error("first pull-up wrong");
    pullup_second_a: assert property (hitSeq(10'h22E) |=>
        pullupControlSecond == $past(accA)) else $error("second pull-up wrong");
    done_pulse_a: assert property (isHit |=> instrDone) else $error("done missing");
    done_idle_a: assert property (!isHit |=> !instrDone) else $error("stray done");
    hold_idle_a: assert property (!isHit |=> $stable(timerCtrlBit)
        && $stable(prescalerCounter) && $stable(prescalerReload)
        && $stable(pullupControlFirst) && $stable(pullupControlSecond))
        else $error("target changed without instruction");
    flags_quiet_a: assert property (!(carryWrite || skipNext)) else $error("carry or skip");
    read_idle_a: assert property (!regRead |=> regRdata == 8'h00) else $error("read data stuck");
endmodule

bind accumulator_transfer_exec accumulator_transfer_exec_assertions chk (
    .core_clk, .reset, .instrValid, .instrWord, .accA, .regB, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .timerCtrlBit, .prescalerCounter, .prescalerReload,
    .pullupControlFirst, .pullupControlSecond, .instrDone, .carryWrite, .skipNext);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic       v;
        logic [9:0] op;
        logic [3:0] a;
        logic [3:0] b;
        logic       done;
    } row_s;
    logic       core_clk   = 1'b0;
    logic       reset      = 1'b1;
    logic       instrValid = 1'b0;
    logic [9:0] instrWord  = 10'h000;
    logic [3:0] accA       = 4'h0;
    logic [3:0] regB       = 4'h0;
    logic [3:0] regAddr    = 4'h0;
    logic [7:0] regWdata   = 8'h00;
    logic       regWrite   = 1'b0;
    logic       regRead    = 1'b0;
    logic [7:0] regRdata, prescalerCounter, prescalerReload;
    logic [3:0] pullupControlFirst, pullupControlSecond;
    logic       timerCtrlBit, instrDone, carryWrite, skipNext;
    int         num_errors = 0;
    int         num_checks = 0;
    logic       eT = 1'b0;
    logic [7:0] eC = 8'h00;
    logic [3:0] eP0 = 4'h0, eP1 = 4'h0, eCnt = 4'h0;
    row_s       rows [10] = '{
        '{1'b1, 10'h2AA, 4'hF, 4'h0, 1'b1}, '{1'b1, 10'h2AA, 4'hE, 4'hF, 1'b1},
        '{1'b1, 10'h235, 4'h5, 4'hA, 1'b1}, '{1'b1, 10'h22D, 4'h9, 4'h3, 1'b1},
        '{1'b1, 10'h22E, 4'h6, 4'hC, 1'b1}, '{1'b0, 10'h22E, 4'h1, 4'h1, 1'b0},
        '{1'b1, 10'h2AB, 4'h3, 4'h3, 1'b0}, '{1'b1, 10'h235, 4'h0, 4'hF, 1'b1},
        '{1'b1, 10'h22D, 4'hF, 4'hF, 1'b1}, '{1'b1, 10'h22E, 4'hF, 4'h0, 1'b1}};

    accumulator_transfer_exec dut (
        .core_clk, .reset, .instrValid, .instrWord, .accA, .regB, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .timerCtrlBit, .prescalerCounter, .prescalerReload,
        .pullupControlFirst, .pullupControlSecond, .instrDone, .carryWrite, .skipNext);

    always #2.5 core_clk = ~core_clk;

    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task checkOuts(input logic d);
        chk("timerCtrlBit", {7'h00, eT}, {7'h00, timerCtrlBit});
        chk("prescalerCounter", eC, prescalerCounter);
        chk("prescalerReload", eC, prescalerReload);
        chk("pullupControlFirst", {4'h0, eP0}, {4'h0, pullupControlFirst});
        chk("pullupControlSecond", {4'h0, eP1}, {4'h0, pullupControlSecond});
        chk("instrDone", {7'h00, d}, {7'h00, instrDone});
        chk("carryWrite skipNext", 8'h00, {6'h00, carryWrite, skipNext});
    endtask

    task apply(input row_s r, input logic en);
        if (r.v && en && (r.op inside {10'h2AA, 10'h235, 10'h22D, 10'h22E})) eCnt++;
        if (r.v && en) begin
            case (r.op)
                10'h2AA: eT = r.a[0];
                10'h235: eC = {r.b, r.a};
                10'h22D: eP0 = r.a;
                10'h22E: eP1 = r.a;
                default: ;
            endcase
        end
    endtask

    task drive(input row_s r);
        instrValid <= r.v;
        instrWord <= r.op;
        accA <= r.a;
        regB <= r.b;
    endtask

    task exec(input row_s r, input logic en);
        @(posedge core_clk);
        drive(r);
        @(posedge core_clk);
        drive('0);
        #1;
        apply(r, en);
        checkOuts(r.done & en);
    endtask

    task regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task regRd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk("regRdata", e, regRdata);
        @(posedge core_clk);
        #1;
        chk("regRdata idle", 8'h00, regRdata);
    endtask

    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        checkOuts(1'b0);
        regRd(transfer_pkg::ADDR_CTRL, 8'h01);
        // Back to back: each row is taken while the next one is driven
        for (int i = 0; i <= 10; i++) begin
            @(posedge core_clk);
            if (i < 10) drive(rows[i]);
            else drive('0);
            #1;
            if (i > 0) begin
                apply(rows[i-1], 1'b1);
                checkOuts(rows[i-1].done);
            end
        end
        regRd(transfer_pkg::ADDR_STATUS, {eCnt, 1'b0, 3'h6});
        regRd(transfer_pkg::ADDR_PRESC_CNT, eC);
        regRd(transfer_pkg::ADDR_PRESC_RLD, eC);
        regRd(transfer_pkg::ADDR_TIMER_BIT, {7'h00, eT});
        // Both pull-ups hold F here, so a landed write of zero would show
        regWr(transfer_pkg::ADDR_PULLUP, 8'h00);
        regRd(transfer_pkg::ADDR_PULLUP, {eP1, eP0});
        regRd(4'hF, 8'h00);
        regWr(transfer_pkg::ADDR_CTRL, 8'h00);
        exec('{1'b1, 10'h2AA, 4'h1, 4'h0, 1'b1}, 1'b0);
        exec('{1'b1, 10'h235, 4'h7, 4'h8, 1'b1}, 1'b0);
        regRd(transfer_pkg::ADDR_CTRL, 8'h00);
        regWr(transfer_pkg::ADDR_CTRL, 8'h01);
        exec('{1'b1, 10'h2AA, 4'h1, 4'h0, 1'b1}, 1'b1);
        exec('{1'b1, 10'h235, 4'h7, 4'h8, 1'b1}, 1'b1);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        eT = 1'b0;
        eC = 8'h00;
        eP0 = 4'h0;
        eP1 = 4'h0;
        checkOuts(1'b0);
        regRd(transfer_pkg::ADDR_CTRL, 8'h01);
        regRd(transfer_pkg::ADDR_STATUS, 8'h00);
        exec('{1'b1, 10'h22E, 4'hA, 4'h5, 1'b1}, 1'b1);
        regRd(transfer_pkg::ADDR_STATUS, {4'h1, 1'b0, 3'h6});
        conclude();
    end
endmodule
